// File: include/ufbt_pkg.sv
// ufbt_pkg: shared constants and types for the serial frame transmitter
`default_nettype none
package ufbt_pkg;

	// register byte offsets on the apb bus
	localparam logic [7:0] OFS_CONTROL_ONE = 8'h00; // serial_control_one
	localparam logic [7:0] OFS_CONTROL_TWO = 8'h04; // serial_control_two
	localparam logic [7:0] OFS_DIVIDER     = 8'h08; // baud_divider_value
	localparam logic [7:0] OFS_TX_DATA     = 8'h0C; // transmit data
	localparam logic [7:0] OFS_STATUS      = 8'h10; // busy status
	localparam logic [7:0] OFS_SYSTEM      = 8'h14; // system_control_one

	// serial_control_one field positions
	localparam int BIT_TX_ENABLE   = 7;
	localparam int BIT_STOP_LENGTH = 5;
	localparam int BIT_EVEN        = 4;
	localparam int BIT_PARITY_EN   = 3;
	localparam int BIT_INFRARED    = 2;
	localparam int BIT_BASE_SEL    = 1;
	// serial_control_two field positions
	localparam int LSB_PER_BIT   = 3;
	localparam int LSB_NOISE_REJ = 1;
	// system_control_one field positions
	localparam int BIT_PIN_OUT_EN = 0;
	localparam int BIT_STOP_MODE  = 1;
	localparam int BIT_IDLE_MODE  = 2;
	localparam int BIT_SLEEP_MODE = 3;

	// per-bit select codes
	localparam logic [2:0] PER_BIT_16    = 3'h0;
	localparam logic [2:0] PER_BIT_16_17 = 3'h1;
	localparam logic [2:0] PER_BIT_15    = 3'h2;
	localparam logic [2:0] PER_BIT_15_16 = 3'h3;
	localparam logic [2:0] PER_BIT_17    = 3'h4;
	localparam logic [4:0] COUNT_15 = 5'h0F;
	localparam logic [4:0] COUNT_16 = 5'h10;
	localparam logic [4:0] COUNT_17 = 5'h11;

	// frame shape
	localparam logic [3:0] DATA_BITS  = 4'h8;
	localparam logic [3:0] FRAME_BASE = 4'hA; // start, data, one stop
	// infrared pulse spans this many base ticks (3/16 of a bit)
	localparam logic [4:0] IR_PULSE_TICKS = 5'h03;

	// settings that steer the transmitter
	typedef struct packed
	{
		logic       tx_enable;
		logic       stop_bit_length;
		logic       even;
		logic       parity_enable;
		logic       infrared;
		logic       base_sel;
		logic [2:0] per_bit;
		logic [7:0] baud_divider_value;
	} ufbt_cfg_t;

	// power mode requests
	typedef struct packed
	{
		logic pin_out_en;
		logic stop_mode;
		logic idle_mode;
		logic sleep_mode;
	} ufbt_pwr_t;

endpackage
`default_nettype wire

// File: verilog/ufbt_baud.sv
// ufbt_baud: base tick divider; per-bit tick count selection is in ufbt_top
`timescale 1ns/1ps
`default_nettype none
module ufbt_baud
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,        // counting while a frame is live
	input  wire logic       slow_tick,  // alternate source enable
	input  wire logic       base_sel,   // 0: pclk, 1: slow_tick
	input  wire logic [7:0] divider,    // baud_divider_value
	output logic            base_tick   // one pclk per base clock
);
	logic [7:0] count; // divider position

	// source pulse: every pclk or the slow enable
	logic src;
	assign src = base_sel ? slow_tick : 1'b1;

	// count divider+1 source pulses per base tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= 8'h00;
		else if (!run)
			count <= 8'h00;
		else if (src)
			count <= (count == divider) ? 8'h00 : count + 8'h01;
	end

	// pulse out on wrap; stays combinational as a handshake-like strobe
	assign base_tick = run && src && (count == divider);

	// with pclk as source, a base tick is never followed by another on the next pclk unless divider is zero
	divider_span_a: assert property (@(posedge pclk)
		disable iff (!presetn) (base_tick && !base_sel && run) |=>
		(!base_tick) [*1] or (divider == 8'h00))
		else $error("base tick repeated too early");
endmodule
`default_nettype wire

// File: verilog/ufbt_top.sv
// ufbt_top: apb-controlled serial frame transmitter with pin power modes
// Behaviour
// - low-power entry forces pin level by infrared; stop mode without pin_out_en floats the pin instead
// - frame starts low, then eight data bits
// - parity optional, even or odd select
// - one or two stop bits selectable
// - order start, data lsb first, parity, stop
// - infrared select emits short pulse format
// - rate from source, divider, per-bit select
// - tables assume noise rejection zero
// - base clock is divider plus one counts
// - per-bit select gives 16,16/17,15,15/16,17
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ufbt_top
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        slow_clock_pin,     // alternate base source
	output logic             serial_transmit_pin,
	output logic             serial_transmit_oe   // high while driving
);
	logic [7:0] ctl_one;   // serial_control_one
	logic [7:0] ctl_two;   // serial_control_two
	logic [7:0] div_val;   // baud_divider_value
	logic [7:0] tx_data;   // last written data
	logic [3:0] sys_one;   // system_control_one
	logic       tx_start;  // data written, frame pending
	logic       busy;      // frame in flight
	ufbt_pkg::ufbt_cfg_t cfg; // frame and rate settings
	ufbt_pkg::ufbt_pwr_t pwr; // power mode requests

	assign cfg = '{ctl_one[ufbt_pkg::BIT_TX_ENABLE],
		ctl_one[ufbt_pkg::BIT_STOP_LENGTH], ctl_one[ufbt_pkg::BIT_EVEN],
		ctl_one[ufbt_pkg::BIT_PARITY_EN], ctl_one[ufbt_pkg::BIT_INFRARED],
		ctl_one[ufbt_pkg::BIT_BASE_SEL],
		ctl_two[ufbt_pkg::LSB_PER_BIT +: 3], div_val};
	assign pwr = '{sys_one[ufbt_pkg::BIT_PIN_OUT_EN],
		sys_one[ufbt_pkg::BIT_STOP_MODE], sys_one[ufbt_pkg::BIT_IDLE_MODE],
		sys_one[ufbt_pkg::BIT_SLEEP_MODE]};

	logic low_power; // any low-power mode active
	assign low_power = pwr.stop_mode | pwr.idle_mode | pwr.sleep_mode;

	// apb: zero wait states, error on unmapped address
	logic access;
	logic mapped;
	assign access  = psel && penable;
	assign pready  = 1'b1;
	assign mapped  = (paddr == ufbt_pkg::OFS_CONTROL_ONE)
		|| (paddr == ufbt_pkg::OFS_CONTROL_TWO)
		|| (paddr == ufbt_pkg::OFS_DIVIDER)
		|| (paddr == ufbt_pkg::OFS_TX_DATA)
		|| (paddr == ufbt_pkg::OFS_STATUS)
		|| (paddr == ufbt_pkg::OFS_SYSTEM);
	assign pslverr = access && !mapped;

	// register writes; settings hold only while idle so a frame stays whole
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl_one <= 8'h00;
			ctl_two <= 8'h00; // noise rejection 0y00 by default
			div_val <= 8'h00;
			tx_data <= 8'h00;
			sys_one <= 4'h0;
		end
		else if (access && pwrite)
		begin
			case (paddr)
				ufbt_pkg::OFS_CONTROL_ONE:
					if (!busy)
						ctl_one <= pwdata[7:0];
				ufbt_pkg::OFS_CONTROL_TWO:
					if (!busy)
						ctl_two <= pwdata[7:0];
				ufbt_pkg::OFS_DIVIDER:
					if (!busy)
						div_val <= pwdata[7:0];
				ufbt_pkg::OFS_TX_DATA:
					tx_data <= pwdata[7:0];
				ufbt_pkg::OFS_SYSTEM:
					sys_one <= pwdata[3:0];
				default:
					sys_one <= sys_one;
			endcase
		end
		else if (low_power)
			ctl_one[ufbt_pkg::BIT_TX_ENABLE] <= 1'b0; // mode entry stops it
	end

	// pending-frame flag: write sets, frame launch or power mode clears
	logic launch;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_start <= 1'b0;
		else if (access && pwrite && paddr == ufbt_pkg::OFS_TX_DATA)
			tx_start <= 1'b1; // set wins over clear
		else if (launch || low_power)
			tx_start <= 1'b0;
	end

	// read data is registered-state muxing
	always_comb
	begin
		prdata = 32'h0000_0000;
		case (paddr)
			ufbt_pkg::OFS_CONTROL_ONE: prdata[7:0] = ctl_one;
			ufbt_pkg::OFS_CONTROL_TWO: prdata[7:0] = ctl_two;
			ufbt_pkg::OFS_DIVIDER:     prdata[7:0] = div_val;
			ufbt_pkg::OFS_TX_DATA:     prdata[7:0] = tx_data;
			ufbt_pkg::OFS_STATUS:      prdata[1:0] = {tx_start, busy};
			ufbt_pkg::OFS_SYSTEM:      prdata[3:0] = sys_one;
			default:                   prdata = 32'h0000_0000;
		endcase
	end

	// slow source pin: synchronise, then edge-detect on the second stage
	logic [2:0] slow_sync;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			slow_sync <= 3'h0;
		else
			slow_sync <= {slow_sync[1:0], slow_clock_pin};
	end
	logic slow_tick;
	assign slow_tick = slow_sync[1] & ~slow_sync[2];

	logic base_tick;
	ufbt_baud u_baud
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.run       (busy),
		.slow_tick (slow_tick),
		.base_sel  (cfg.base_sel),
		.divider   (cfg.baud_divider_value),
		.base_tick (base_tick)
	);

	// frame state
	logic [3:0]  bit_idx;   // position in frame, 0 = start
	logic [4:0]  tick_cnt;  // base ticks within current bit
	logic [10:0] shifter;   // data, parity, stops from bit 1 on
	logic [3:0]  frame_len;
	logic        parity;
	logic [4:0]  bit_ticks;

	assign launch = tx_start && !busy && cfg.tx_enable && !low_power;
	// even parity makes total ones even
	assign parity = (^tx_data) ^ ~cfg.even;
	assign frame_len = ufbt_pkg::FRAME_BASE
		+ {3'h0, cfg.parity_enable} + {3'h0, cfg.stop_bit_length};

	// ticks per bit; alternating codes toggle on odd bit positions
	always_comb
	begin
		case (cfg.per_bit)
			ufbt_pkg::PER_BIT_16:    bit_ticks = ufbt_pkg::COUNT_16;
			ufbt_pkg::PER_BIT_16_17: bit_ticks = bit_idx[0] ?
				ufbt_pkg::COUNT_17 : ufbt_pkg::COUNT_16;
			ufbt_pkg::PER_BIT_15:    bit_ticks = ufbt_pkg::COUNT_15;
			ufbt_pkg::PER_BIT_15_16: bit_ticks = bit_idx[0] ?
				ufbt_pkg::COUNT_16 : ufbt_pkg::COUNT_15;
			ufbt_pkg::PER_BIT_17:    bit_ticks = ufbt_pkg::COUNT_17;
			default:                 bit_ticks = ufbt_pkg::COUNT_16;
		endcase
	end

	logic bit_done;
	assign bit_done = base_tick && (tick_cnt == bit_ticks - 5'h01);

	// frame sequencer; power modes abort mid-frame
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy     <= 1'b0;
			bit_idx  <= 4'h0;
			tick_cnt <= 5'h00;
			shifter  <= 11'h7FF;
		end
		else if (low_power)
			busy <= 1'b0;
		else if (launch)
		begin
			busy     <= 1'b1;
			bit_idx  <= 4'h0; // start bit first
			tick_cnt <= 5'h00;
			// lsb first, then parity if enabled, then stops
			shifter  <= cfg.parity_enable ?
				{2'h3, parity, tx_data} : {3'h7, tx_data};
		end
		else if (busy && base_tick)
		begin
			if (bit_done)
			begin
				tick_cnt <= 5'h00;
				if (bit_idx == frame_len - 4'h1)
					busy <= 1'b0;
				else
					bit_idx <= bit_idx + 4'h1;
				if (bit_idx != 4'h0)
					shifter <= {1'b1, shifter[10:1]};
			end
			else
				tick_cnt <= tick_cnt + 5'h01;
		end
	end

	// level-coded bit: start low, else shifter lsb
	logic level_bit;
	assign level_bit = (bit_idx == 4'h0) ? 1'b0 : shifter[0];

	// pin driver: registered for clean output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_transmit_pin <= 1'b1;
			serial_transmit_oe  <= 1'b1;
		end
		else if (pwr.stop_mode && !pwr.pin_out_en)
		begin
			serial_transmit_pin <= 1'b0;
			serial_transmit_oe  <= 1'b0; // float either way
		end
		else if (low_power || !busy)
		begin
			serial_transmit_pin <= ~cfg.infrared;
			serial_transmit_oe  <= 1'b1;
		end
		else if (cfg.infrared)
		begin
			// high pulse for zero bits, low otherwise
			serial_transmit_pin <= !level_bit
				&& tick_cnt < ufbt_pkg::IR_PULSE_TICKS;
			serial_transmit_oe  <= 1'b1;
		end
		else
		begin
			serial_transmit_pin <= level_bit;
			serial_transmit_oe  <= 1'b1;
		end
	end

	pin_low_power_a: assert property (@(posedge pclk)
		disable iff (!presetn) (pwr.idle_mode && !pwr.stop_mode) |=>
		serial_transmit_oe && serial_transmit_pin == ~$past(cfg.infrared))
		else $error("pin level wrong in low power");
	pin_float_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		(pwr.stop_mode && !pwr.pin_out_en) |=> !serial_transmit_oe)
		else $error("pin not floated in stop");
	start_low_a: assert property (@(posedge pclk)
		disable iff (!presetn) (launch && !cfg.infrared) ##1
		(busy && !low_power) |=> !serial_transmit_pin)
		else $error("start bit not low");
	frame_len_a: assert property (@(posedge pclk)
		disable iff (!presetn) busy |-> bit_idx < frame_len)
		else $error("frame ran past its length");
	bit_ticks_a: assert property (@(posedge pclk)
		disable iff (!presetn) busy |-> tick_cnt < bit_ticks)
		else $error("bit tick count overran");
	launch_idle_a: assert property (@(posedge pclk)
		disable iff (!presetn) launch |=> busy && bit_idx == 4'h0)
		else $error("frame did not start");
	ir_idle_a: assert property (@(posedge pclk)
		disable iff (!presetn) (!busy && !low_power && cfg.infrared) [*2]
		|-> !serial_transmit_pin)
		else $error("infrared idle not low");
	parity_place_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		(launch && cfg.parity_enable) |=> shifter[8] == $past(parity))
		else $error("parity bit misplaced");
endmodule
`default_nettype wire

// File: test/ufbt_remote_rx.sv
// ufbt_remote_rx: behavioural far node that samples frames mid-bit
`timescale 1ns/1ps
`default_nettype none
module ufbt_remote_rx
(
	input  wire logic        pclk,
	input  wire logic        rx_line,  // line as seen at the far node
	input  wire logic [7:0]  divider,  // divider the node expects
	input  wire logic [2:0]  per_bit,  // base clocks per bit code
	input  wire logic [3:0]  nbits,    // bits per frame with stop bits
	output logic      [11:0] frame,    // last frame, missing bits read 1
	output logic      [7:0]  frames    // frames taken so far
);
	// base clocks of bit i; alternating codes start on the short count
	function automatic int ticks(input int i);
		case (per_bit)
			3'h0: return 16;
			3'h1: return (i % 2 == 0) ? 16 : 17;
			3'h2: return 15;
			3'h3: return (i % 2 == 0) ? 15 : 16;
			default: return 17;
		endcase
	endfunction
	logic [7:0] taken = 8'h00; // the one place the frame count is kept
	assign frames = taken;
	// a wrong bit count drifts past mid-bit within a frame, so it shows
	always
	begin
		int len;
		logic [11:0] f;
		@(negedge rx_line);
		f = 12'hFFF;
		for (int i = 0; i < nbits; i++)
		begin
			len = ticks(i) * (divider + 1);
			repeat (len / 2) @(posedge pclk);
			f[i] = rx_line;
			repeat (len - len / 2) @(posedge pclk);
		end
		frame = f;
		taken = taken + 8'h01;
	end
endmodule
`default_nettype wire

// File: test/tb_uart_frame_baud_txd_idle.sv
// tb_uart_frame_baud_txd_idle: frames, rates, pulse format, power modes
`timescale 1ns/1ps
`default_nettype none
module tb_uart_frame_baud_txd_idle;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        slow_clock_pin = 1'b0; // alternate source, pclk/2
	logic        pin;                   // serial line
	logic        oe;                    // line driven
	logic        line;                  // line as the far node sees it
	logic [7:0]  div = 8'h00;           // divider the far node expects
	logic [2:0]  code = 3'h0;
	logic [3:0]  nbits = 4'hA;
	logic [11:0] frame;
	logic [7:0]  frames;
	logic [31:0] q;                     // last read data
	logic        err;                   // last slave error
	logic [7:0]  offs [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
	// {pin, oe, infrared, sleep, idle, stop, pin_out_en} after mode entry
	logic [6:0]  pm [7] = '{7'h64, 7'h38, 7'h33, 7'h63, 7'h12, 7'h02, 7'h34};
	int          miscompares = 0;
	int          samples_checked = 0;

	always #5 pclk = ~pclk;
	always @(posedge pclk) slow_clock_pin <= ~slow_clock_pin;
	// a floated line rests high on its pull-up
	assign line = (oe === 1'b1) ? pin : 1'b1;

	ufbt_top ufbt_top_inst
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .slow_clock_pin(slow_clock_pin),
		.serial_transmit_pin(pin), .serial_transmit_oe(oe)
	);
	ufbt_remote_rx ufbt_remote_rx_inst
	(
		.pclk(pclk), .rx_line(line), .divider(div), .per_bit(code),
		.nbits(nbits), .frame(frame), .frames(frames)
	);

	task automatic final_report;
		if (miscompares == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic hang;
		miscompares++;
		final_report;
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 64);
		if (n >= 64)
			hang;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	initial
	begin
		logic [7:0]  d;
		logic [11:0] f;
		logic [31:0] c;
		logic        pe, ev, st, bs;
		int          r, h, p;
		void'($urandom(32'hF4A5));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (offs[i])
		begin
			apb(1'b0, offs[i], 32'h0);
			chk(q, 32'h0);
		end
		apb(1'b0, 8'h18, 32'h0);
		chk(32'(err), 32'h1);
		// random frames over every per-bit code, one from the slow source
		for (int k = 0; k < 10; k++)
		begin
			d = 8'($urandom);
			{pe, ev, st} = 3'($urandom);
			bs = (k == 9);
			code = 3'(k % 5);
			r = (k == 0) ? 8'h19 : $urandom_range(3, 0);
			div = bs ? 8'(2 * r + 1) : 8'(r);
			nbits = 4'(10 + pe + st);
			f = {2'b11, ^d ^ ~ev, d, 1'b0};
			if (!pe)
				f[9] = 1'b1;
			c = {24'h0, 2'b10, st, ev, pe, 1'b0, bs, 1'b0};
			apb(1'b1, 8'h04, 32'(code) << 3);
			apb(1'b1, 8'h08, 32'(r));
			apb(1'b1, 8'h00, c);
			apb(1'b1, 8'h0C, 32'(d));
			h = frames;
			repeat (40) @(posedge pclk);
			apb(1'b1, 8'h00, 32'h0);
			apb(1'b0, 8'h00, 32'h0);
			chk(q, c);
			for (int n = 0; n < 9000 && frames == h; n++)
				@(posedge pclk);
			if (frames == h)
				hang;
			chk(32'(frame), 32'(f));
			// poll count kept apart: r is the divider the pulse check needs
			p = 0;
			do
			begin
				apb(1'b0, 8'h10, 32'h0);
				p++;
			end
			while (q[0] !== 1'b0 && p < 200);
			if (q[0] !== 1'b0)
				hang;
		end
		// pulse format: a short high pulse per zero bit, idle low
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h84);
		d = 8'($urandom);
		apb(1'b1, 8'h0C, 32'(d));
		h = 0;
		// window spans a whole frame at the slowest divider used
		repeat (720)
		begin
			@(posedge pclk);
			h += int'(pin === 1'b1);
		end
		chk(32'(h), 32'((9 - $countones(d)) * 3 * (r + 1)));
		// data written with the transmitter off waits as pending
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h0C, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h2);
		// a mode entry in mid-frame aborts it and parks the line
		apb(1'b1, 8'h00, 32'h80);
		apb(1'b1, 8'h0C, 32'h0);
		repeat (100) @(posedge pclk);
		apb(1'b1, 8'h14, 32'h4);
		repeat (3) @(posedge pclk);
		chk(32'({pin, oe}), 32'h3);
		apb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h0);
		foreach (pm[i])
		begin
			apb(1'b1, 8'h14, 32'h0);
			apb(1'b1, 8'h00, 32'(pm[i][4]) << 2);
			apb(1'b1, 8'h14, 32'(pm[i][3:0]));
			repeat (3) @(posedge pclk);
			chk(32'(oe), 32'(pm[i][5]));
			if (pm[i][5])
				chk(32'(pin), 32'(pm[i][6]));
		end
		final_report;
	end
endmodule
`default_nettype wire
